// >>> logic/rotate_return_map.vh
/*
 Constants for the OR / rotate / return execution block: operation codes,
 register reset values and widths. Assumes the decoder presents one
 operation code per instruction issue.
*/
// Notes on behaviour
// RULE1: OR immediate with accumulator, result to accumulator, update zero flag.
// RULE2: OR accumulator into memory byte, write back, accumulator kept, zero updated.
// RULE3: Subroutine exit pops program counter, fetch resumes there, flags untouched.
// RULE4: Return with literal pops program counter, loads literal into accumulator, flags untouched.
// RULE5: Interrupt exit pops program counter, sets global interrupt enable, flags untouched.
// RULE6: Pending interrupt at interrupt exit is serviced before resuming main program.
// RULE7: Memory rotate up shifts byte left, bit 7 to bit 0, writes back, no flag.
// RULE8: Rotate up into accumulator puts rotated byte in accumulator, memory and flags kept.
// RULE9: Both rotates map source bit i to result bit i+1 for i 0 to 6.
// RULE10: Zero flag set when affected 8-bit result is zero, cleared otherwise.
`ifndef ROTATE_RETURN_MAP_VH
`define ROTATE_RETURN_MAP_VH

`define OP_W               3
`define OP_NONE            3'h0
`define OP_OR_LITERAL      3'h1
`define OP_DISJUNCT_MEM    3'h2
`define OP_SUB_EXIT        3'h3
`define OP_SUB_EXIT_LIT    3'h4
`define OP_IRQ_EXIT        3'h5
`define OP_MEM_ROTATE_UP   3'h6
`define OP_ROTATE_UP_ACC   3'h7

`define ACC_RESET          8'h00
`define ZERO_FLAG_RESET    1'b0
`define GIE_RESET          1'b0
`define PC_W               12
`define PC_RESET           12'h000
`define MEM_WDATA_RESET    8'h00
`define STROBE_RESET       1'b0

`endif

// >>> logic/rotate_or_unit.v
/*
 Combinational datapath: OR and circular left rotate of 8-bit values,
 with zero detect. Assumes inputs are stable within one core cycle.
*/
`timescale 1ns/1ps

module rotate_or_unit (
    input  wire [7:0] acc_in,
    input  wire [7:0] operand_in,
    input  wire       rotate_sel_in,
    output wire [7:0] result_out,
    output wire       zero_out
);
    wire [7:0] rotated;
    genvar i;

    generate
        for (i = 0; i < 7; i = i + 1) begin : g_rot
            assign rotated[i+1] = operand_in[i]; // [RULE9]
        end
    endgenerate
    assign rotated[0] = operand_in[7]; // [RULE7] [RULE8]

    assign result_out = rotate_sel_in ? rotated : (acc_in | operand_in); // [RULE1] [RULE2]
    assign zero_out   = (result_out == 8'h00); // [RULE10]
endmodule // rotate_or_unit

// >>> logic/logic_rotate_return_exec.v
/*
 Execution of the OR, rotate-left and return instruction group. Holds the
 accumulator, zero flag and global interrupt enable. Assumes the decoder
 pulses op_valid_in for one cycle with the operation code, operand byte
 (literal or memory byte) and the stack top; the stack pops on stack_pop_out.
*/
`timescale 1ns/1ps
`include "rotate_return_map.vh"

module logic_rotate_return_exec (
    input  wire                core_clk_in,
    input  wire                rst_n_in,
    input  wire                op_valid_in,
    input  wire [`OP_W-1:0]    op_code_in,
    input  wire [7:0]          operand_in,
    input  wire [`PC_W-1:0]    stack_top_in,
    input  wire                irq_pending_in,
    output wire [7:0]          acc_out,
    output wire                zero_flag_out,
    output wire                global_irq_enable_out,
    output wire                mem_write_out,
    output wire [7:0]          mem_wdata_out,
    output wire                stack_pop_out,
    output wire                pc_load_out,
    output wire [`PC_W-1:0]    pc_value_out,
    output wire                irq_service_out
);
    // Architectural state and registered side-effect strobes
    reg  [7:0]       acc_reg;
    reg  [7:0]       acc_next;
    reg              zero_flag_reg;
    reg              zero_flag_next;
    reg              global_irq_enable_reg;
    reg              global_irq_enable_next;
    reg              mem_write_reg;
    reg              mem_write_next;
    reg  [7:0]       mem_wdata_reg;
    reg  [7:0]       mem_wdata_next;
    reg              stack_pop_reg;
    reg              stack_pop_next;
    reg              pc_load_reg;
    reg              pc_load_next;
    reg  [`PC_W-1:0] pc_value_reg;
    reg  [`PC_W-1:0] pc_value_next;
    reg              irq_service_reg;
    reg              irq_service_next;

    // Decoded instruction, qualified by the issue strobe except the rotate select
    wire             do_or_literal;
    wire             do_disjunct_mem;
    wire             do_sub_exit_lit;
    wire             do_irq_exit;
    wire             do_mem_rotate;
    wire             do_rotate_acc;
    wire             do_return;
    wire             do_rotate;
    wire             sets_zero;
    wire [7:0]       alu_result;
    wire             alu_zero;

    // True when an issued op carries the given code
    function op_hit;
        input             valid;
        input [`OP_W-1:0] op;
        input [`OP_W-1:0] code;
        begin
            op_hit = valid && (op == code);
        end
    endfunction

    // Any of the three stack-popping exits
    function is_return;
        input [`OP_W-1:0] op;
        begin
            is_return = (op == `OP_SUB_EXIT) || (op == `OP_SUB_EXIT_LIT)
                     || (op == `OP_IRQ_EXIT);
        end
    endfunction

    // Either rotate form; the datapath steers on this without the strobe
    function is_rotate;
        input [`OP_W-1:0] op;
        begin
            is_rotate = (op == `OP_MEM_ROTATE_UP) || (op == `OP_ROTATE_UP_ACC);
        end
    endfunction

    assign do_or_literal   = op_hit(op_valid_in, op_code_in, `OP_OR_LITERAL);
    assign do_disjunct_mem = op_hit(op_valid_in, op_code_in, `OP_DISJUNCT_MEM);
    assign do_sub_exit_lit = op_hit(op_valid_in, op_code_in, `OP_SUB_EXIT_LIT);
    assign do_irq_exit     = op_hit(op_valid_in, op_code_in, `OP_IRQ_EXIT);
    assign do_mem_rotate   = op_hit(op_valid_in, op_code_in, `OP_MEM_ROTATE_UP);
    assign do_rotate_acc   = op_hit(op_valid_in, op_code_in, `OP_ROTATE_UP_ACC);
    assign do_return       = op_valid_in && is_return(op_code_in);
    assign do_rotate       = is_rotate(op_code_in);
    // Only the two OR forms touch the zero flag
    assign sets_zero       = do_or_literal || do_disjunct_mem;

    rotate_or_unit u_alu (
        .acc_in        (acc_reg),
        .operand_in    (operand_in),
        .rotate_sel_in (do_rotate),
        .result_out    (alu_result),
        .zero_out      (alu_zero)
    );

    // Accumulator: OR literal, literal load on return, rotate into acc
    always @* begin
        acc_next = acc_reg;
        if (do_or_literal) begin
            acc_next = alu_result; // [RULE1]
        end else if (do_sub_exit_lit) begin
            acc_next = operand_in; // [RULE4]
        end else if (do_rotate_acc) begin
            acc_next = alu_result; // [RULE8]
        end
    end

    // Zero flag follows the 8-bit OR result; rotates and returns leave it
    always @* begin
        zero_flag_next = zero_flag_reg;
        if (sets_zero) begin
            zero_flag_next = alu_zero; // [RULE10]
        end
    end

    // Enable is only ever set here; clearing belongs to the interrupt logic
    always @* begin
        global_irq_enable_next = global_irq_enable_reg;
        if (do_irq_exit) begin
            global_irq_enable_next = 1'b1; // [RULE5]
        end
    end

    // Memory write strobe and data for the two write-back forms
    always @* begin
        mem_write_next = 1'b0;
        mem_wdata_next = mem_wdata_reg;
        if (do_disjunct_mem) begin
            mem_write_next = 1'b1; // [RULE2]
            mem_wdata_next = alu_result; // [RULE2]
        end else if (do_mem_rotate) begin
            mem_write_next = 1'b1; // [RULE7]
            mem_wdata_next = alu_result; // [RULE7]
        end
    end

    // Stack pop and program counter reload for every exit
    always @* begin
        stack_pop_next = 1'b0;
        pc_load_next   = 1'b0;
        pc_value_next  = pc_value_reg;
        if (do_return) begin
            stack_pop_next = 1'b1; // [RULE3]
            pc_load_next   = 1'b1; // [RULE3]
            pc_value_next  = stack_top_in; // [RULE3]
        end
    end

    // Tells the interrupt logic to take the pending request before main flow
    always @* begin
        irq_service_next = 1'b0;
        if (do_irq_exit) begin
            irq_service_next = irq_pending_in; // [RULE6]
        end
    end

    always @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            acc_reg <= `ACC_RESET;
        end else begin
            acc_reg <= acc_next;
        end
    end

    always @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            zero_flag_reg <= `ZERO_FLAG_RESET;
        end else begin
            zero_flag_reg <= zero_flag_next;
        end
    end

    always @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            global_irq_enable_reg <= `GIE_RESET;
        end else begin
            global_irq_enable_reg <= global_irq_enable_next;
        end
    end

    always @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            mem_write_reg <= `STROBE_RESET;
        end else begin
            mem_write_reg <= mem_write_next;
        end
    end

    always @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            mem_wdata_reg <= `MEM_WDATA_RESET;
        end else begin
            mem_wdata_reg <= mem_wdata_next;
        end
    end

    always @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            stack_pop_reg <= `STROBE_RESET;
        end else begin
            stack_pop_reg <= stack_pop_next;
        end
    end

    always @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pc_load_reg <= `STROBE_RESET;
        end else begin
            pc_load_reg <= pc_load_next;
        end
    end

    always @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pc_value_reg <= `PC_RESET;
        end else begin
            pc_value_reg <= pc_value_next;
        end
    end

    always @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            irq_service_reg <= `STROBE_RESET;
        end else begin
            irq_service_reg <= irq_service_next;
        end
    end

    // Every output comes straight from its flip-flop
    assign acc_out               = acc_reg;
    assign zero_flag_out         = zero_flag_reg;
    assign global_irq_enable_out = global_irq_enable_reg;
    assign mem_write_out         = mem_write_reg;
    assign mem_wdata_out         = mem_wdata_reg;
    assign stack_pop_out         = stack_pop_reg;
    assign pc_load_out           = pc_load_reg;
    assign pc_value_out          = pc_value_reg;
    assign irq_service_out       = irq_service_reg;
endmodule // logic_rotate_return_exec

// >>> dv/mem_stack_model.sv
/* Data memory byte and stack model; assumes one pop or write per cycle. */
`timescale 1ns/1ps
module mem_stack_model (
    input  wire        core_clk_in,
    input  wire        mem_write_in,
    input  wire [7:0]  mem_wdata_in,
    input  wire        stack_pop_in,
    output reg  [7:0]  mem_byte_out = 8'h81,
    output reg  [11:0] stack_top_out = 12'h5a3
);
    always @(posedge core_clk_in) begin
        if (mem_write_in) mem_byte_out <= mem_wdata_in;
        if (stack_pop_in) stack_top_out <= stack_top_out - 12'h011;
    end
endmodule // mem_stack_model

// >>> dv/logic_rotate_return_exec_checker.sv
/* Checker for the OR, rotate and return block; assumes one clock domain. */
`timescale 1ns/1ps
`include "rotate_return_map.vh"
module rr_checker (
    input wire core_clk_in, rst_n_in, op_valid_in, irq_pending_in, zero_flag_out,
    input wire global_irq_enable_out, mem_write_out, stack_pop_out, pc_load_out, irq_service_out,
    input wire [`OP_W-1:0] op_code_in,
    input wire [7:0] operand_in, acc_out, mem_wdata_out,
    input wire [`PC_W-1:0] stack_top_in, pc_value_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);
    wire [2:0] c = op_valid_in ? op_code_in : 3'h0;
    wire [7:0] r = {operand_in[6:0], operand_in[7]};
    wire [7:0] o = acc_out | operand_in;
    property p_or_lit; c == `OP_OR_LITERAL |=> acc_out == $past(o) && zero_flag_out == !acc_out;
    endproperty
    a_or_lit: assert property (p_or_lit) else $error("or literal");
    property p_or_mem; c == `OP_DISJUNCT_MEM |=> mem_write_out && mem_wdata_out == $past(o)
        && $stable(acc_out) && zero_flag_out == !mem_wdata_out; endproperty
    a_or_mem: assert property (p_or_mem) else $error("or into memory");
    property p_pop; c >= `OP_SUB_EXIT && c <= `OP_IRQ_EXIT |=> stack_pop_out && pc_load_out
        && pc_value_out == $past(stack_top_in) && $stable(zero_flag_out); endproperty
    a_pop: assert property (p_pop) else $error("return pop");
    property p_lit; c == `OP_SUB_EXIT_LIT |=> acc_out == $past(operand_in); endproperty
    a_lit: assert property (p_lit) else $error("return literal");
    property p_irq; c == `OP_IRQ_EXIT |=> global_irq_enable_out; endproperty
    a_irq: assert property (p_irq) else $error("irq enable");
    property p_svc; irq_service_out == ($past(c) == `OP_IRQ_EXIT && $past(irq_pending_in));
    endproperty
    a_svc: assert property (p_svc) else $error("pending service");
    property p_rot_mem; c == `OP_MEM_ROTATE_UP |=> mem_write_out && mem_wdata_out == $past(r)
        && $stable(zero_flag_out) && $stable(acc_out); endproperty
    a_rot_mem: assert property (p_rot_mem) else $error("memory rotate");
    property p_rot_acc; c == `OP_ROTATE_UP_ACC |=> acc_out == $past(r) && !mem_write_out
        && $stable(zero_flag_out); endproperty
    a_rot_acc: assert property (p_rot_acc) else $error("rotate to acc");
    c_svc: cover property (c == `OP_IRQ_EXIT && irq_pending_in);
    c_write: cover property (mem_write_out);
    c_load: cover property (pc_load_out);
endmodule // rr_checker
bind logic_rotate_return_exec rr_checker u_rr_checker (.*);

// >>> dv/logic_rotate_return_exec_tb.sv
/* Bench for the OR, rotate and return block; memory and stack come from the model. */
`timescale 1ns/1ps
`include "rotate_return_map.vh"
module logic_rotate_return_exec_tb;
    reg clk = 0, rst_n = 0, vld = 0, irq = 0;
    reg [2:0] op = 0;
    reg [7:0] opd = 0, m;
    reg [11:0] pc;
    integer n_errors = 0, checked = 0;
    wire [7:0] acc, wd, mb;
    wire [11:0] top, pcv;
    wire z, gie, mw, pop, pl, svc;
    logic_rotate_return_exec u_logic_rotate_return_exec (.core_clk_in(clk), .rst_n_in(rst_n),
        .op_valid_in(vld), .op_code_in(op), .operand_in(opd), .stack_top_in(top),
        .irq_pending_in(irq), .acc_out(acc), .zero_flag_out(z), .global_irq_enable_out(gie),
        .mem_write_out(mw), .mem_wdata_out(wd), .stack_pop_out(pop), .pc_load_out(pl),
        .pc_value_out(pcv), .irq_service_out(svc));
    mem_stack_model u_mem_stack_model (.core_clk_in(clk), .mem_write_in(mw),
        .mem_wdata_in(wd), .stack_pop_in(pop), .mem_byte_out(mb), .stack_top_out(top));
    initial forever #4 clk = ~clk;
    task cmp(input [63:0] nm, input [11:0] exp, input [11:0] got); begin
        checked = checked + 1;
        if (got !== exp) begin
            n_errors = n_errors + 1;
            $display("CHECK FAILED %0s expected %h seen %h", nm, exp, got);
        end end endtask
    task issue(input [2:0] c, input [7:0] d, input i); begin
        @(posedge clk);
        vld <= 1; op <= c; opd <= d; irq <= i;
        @(posedge clk);
        m = mb;
        pc = top;
        vld <= 0;
        #1; end endtask
    task t_or; begin
        issue(`OP_OR_LITERAL, 8'h00, 0); cmp("zero", 1, z);
        issue(`OP_OR_LITERAL, 8'h50, 0); cmp("acc", 8'h50, acc);
        cmp("zero", 0, z);
        issue(`OP_DISJUNCT_MEM, mb, 0); cmp("wdata", m | 8'h50, wd);
        cmp("acc", 8'h50, acc);
        $display("test or done"); end endtask
    task t_rot; begin
        @(posedge clk);
        #1;
        issue(`OP_MEM_ROTATE_UP, mb, 0); cmp("wdata", {m[6:0], m[7]}, wd);
        cmp("write", 1, mw);
        @(posedge clk);
        #1;
        issue(`OP_ROTATE_UP_ACC, mb, 0); cmp("acc", {m[6:0], m[7]}, acc);
        cmp("write", 0, mw);
        $display("test rotate done"); end endtask
    task t_ret; begin
        issue(`OP_SUB_EXIT, 8'h00, 0); cmp("pc", pc, pcv);
        cmp("pop", 1, pop);
        cmp("load", 1, pl);
        issue(`OP_SUB_EXIT_LIT, 8'h00, 0); cmp("acc", 0, acc);
        cmp("zero", 0, z);
        cmp("gie", 0, gie);
        issue(`OP_IRQ_EXIT, 8'h00, 1); cmp("gie", 1, gie);
        cmp("service", 1, svc);
        issue(`OP_IRQ_EXIT, 8'h00, 0); cmp("service", 0, svc);
        cmp("pc", pc, pcv);
        cmp("load", 1, pl);
        $display("test return done"); end endtask
    task t_rst; begin
        @(posedge clk);
        rst_n <= 0;
        repeat (2) @(posedge clk);
        #1;
        cmp("gie", 0, gie);
        cmp("pc", 0, pcv);
        cmp("zero", 0, z);
        @(posedge clk);
        rst_n <= 1;
        issue(`OP_OR_LITERAL, 8'h0f, 0); cmp("acc", 8'h0f, acc);
        cmp("zero", 0, z);
        $display("test reset done"); end endtask
    task give_verdict; begin
        $display("checks %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish; end endtask
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1;
        t_or; t_rot; t_ret; t_rst;
        give_verdict;
    end
endmodule // logic_rotate_return_exec_tb
